/* design/sps_capture.sv */
// Strobe phase shift and double data rate capture of one data group
//
// How it works
// - Delay strobes by one selectable phase angle
// - Four DLL modes, each with its own angles
// - Setting tracks reference period continuously, feeds all
// - Each strobe has its own fine delay block
// - Three registers and one latch per cell
// - By-4 mode captures at most four pins
// - By-9 mode captures nine pins, one parity
// - By-18 and by-36 modes, two/four parity
// - Unused group pins are released as plain I/O
// - Capture only in capable banks, all widths
// - Strobe inputs are independent single-ended inputs
// - Echo mode: complement clocks the falling capture
`timescale 1ns/1ps
`default_nettype none
`include "sps_defines.svh"

module sps_capture
  import sps_pkg::*;
#(
  parameter int DQ_W          = 36,
  parameter int DEPTH         = 64,
  parameter bit BANK_CAPABLE  = 1'b1
) (
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  input  wire logic                strobe,
  input  wire logic                complement_strobe,
  input  wire logic                ref_clk_pin,
  input  wire logic [DQ_W-1:0]     data_pin,
  input  wire logic [1:0]          dll_mode,
  input  wire logic [2:0]          phase_sel,
  input  wire logic [1:0]          group_mode,
  input  wire logic                echo_mode,
  input  wire logic [DQ_W-1:0]     release_mask,
  input  wire logic [1:0]          fine_adj_strobe,
  input  wire logic [1:0]          fine_adj_comp,
  output var  logic [DQ_W-1:0]     q_rise,
  output var  logic [DQ_W-1:0]     q_fall,
  output var  logic                pair_valid,
  output var  logic [DQ_W-1:0]     pin_is_gpio,
  output var  logic [DQ_W-1:0]     gpio_in,
  output var  logic                dll_locked
);

  localparam int TAP_W = $clog2(DEPTH);

  initial begin
    if (DQ_W < 4 || DQ_W > 36) begin
      $error("sps_capture: DQ_W must lie in 4..36");
    end
    if (DEPTH < 16) begin
      $error("sps_capture: DEPTH must be at least 16");
    end
  end

  // Pin synchronisers; the first stage feeds only the second
  logic [1:0]      stb_m;
  logic [1:0]      stb_s;
  logic [DQ_W-1:0] data_m;
  logic [DQ_W-1:0] data_s;
  logic            ref_m;
  logic            ref_s;
  logic            ref_d;

  // Strobe and complement run through separate chains, never compared
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stb_m  <= 2'b00;
      stb_s  <= 2'b00;
      data_m <= '0;
      data_s <= '0;
      ref_m  <= 1'b0;
      ref_s  <= 1'b0;
      ref_d  <= 1'b0;
    end else begin
      stb_m  <= {complement_strobe, strobe};
      stb_s  <= stb_m;
      data_m <= data_pin;
      data_s <= data_m;
      ref_m  <= ref_clk_pin;
      ref_s  <= ref_m;
      ref_d  <= ref_s;
    end
  end

  // Reference period measurement
  logic       ref_rise;
  logic [7:0] ref_cnt;
  logic [7:0] ref_period;
  logic [7:0] ref_period_prev;

  assign ref_rise = ref_s & ~ref_d;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ref_cnt         <= `SPS_PERIOD_RST;
      ref_period      <= `SPS_PERIOD_RST;
      ref_period_prev <= `SPS_PERIOD_RST;
    end else if (ref_rise) begin
      ref_cnt         <= `SPS_PERIOD_RST;
      ref_period      <= (ref_cnt == `SPS_PERIOD_SAT) ? ref_cnt
                                                       : ref_cnt + 8'd1;
      ref_period_prev <= ref_period;
    end else if (ref_cnt != `SPS_PERIOD_SAT) begin
      ref_cnt <= ref_cnt + 8'd1;
    end
  end

  // Angle from mode and index; an index beyond the mode gives no shift
  logic [10:0] step;
  logic [2:0]  idx_max;
  logic [10:0] angle;

  always_comb begin
    idx_max = `SPS_IDX_MAX;
    case (sps_dll_mode_t'(dll_mode))
      SPS_DLL_M16: step = `SPS_STEP_M16;
      SPS_DLL_M12: step = `SPS_STEP_M12;
      SPS_DLL_M10: step = `SPS_STEP_M10;
      default: begin
        step    = `SPS_STEP_M8;
        idx_max = `SPS_IDX_MAX_M8;
      end
    endcase
    if (phase_sel <= idx_max) begin
      angle = 11'(phase_sel * step);
    end else begin
      angle = 11'd0;
    end
  end

  // Shared setting: cycles of delay for the chosen fraction of a period
  logic [18:0] prod;
  logic [7:0]  dll_setting;

  // Both operands widened first so the product cannot wrap at 11 bits
  assign prod = 19'(ref_period) * 19'(angle);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dll_setting <= `SPS_SETTING_RST;
    end else begin
      dll_setting <= 8'(prod / `SPS_FULL_TURN);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dll_locked <= 1'b0;
    end else begin
      dll_locked <= (ref_period == ref_period_prev) &&
                    (ref_period != `SPS_PERIOD_RST);
    end
  end

  // Per-input local delay; fine offset trims the shared setting
  logic [1:0]       fine [2];
  logic [TAP_W-1:0] tap  [2];
  logic [1:0]       shifted;
  logic [1:0]       shifted_d;

  assign fine[0] = fine_adj_strobe;
  assign fine[1] = fine_adj_comp;

  for (genvar s = 0; s < 2; s++) begin : g_stb
    logic [8:0] sum;
    assign sum    = {1'b0, dll_setting} + {7'd0, fine[s]};
    // Saturates so a slow reference cannot wrap the tap
    assign tap[s] = (sum > 9'(DEPTH - 1)) ? TAP_W'(DEPTH - 1)
                                          : TAP_W'(sum);
    sps_delay_line #(.DEPTH(DEPTH)) u_line (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .din     (stb_s[s]),
      .tap     (tap[s]),
      .dout    (shifted[s])
    );
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      shifted_d <= 2'b00;
    end else begin
      shifted_d <= shifted;
    end
  end

  logic rise_ev;
  logic comp_rise;
  logic fall_ev;

  assign rise_ev   = shifted[0] & ~shifted_d[0] & BANK_CAPABLE;
  assign comp_rise = shifted[1] & ~shifted_d[1];
  // Echo mode takes the falling capture from the shifted complement
  assign fall_ev   = (echo_mode ? comp_rise
                                : (~shifted[0] & shifted_d[0]))
                     & BANK_CAPABLE;

  // Active pins per group width; the rest go to plain I/O
  logic [5:0]      width;
  logic [DQ_W-1:0] active;

  always_comb begin
    case (sps_group_t'(group_mode))
      SPS_X4:  width = `SPS_W_X4;
      SPS_X9:  width = `SPS_W_X9;
      SPS_X18: width = `SPS_W_X18;
      default: width = `SPS_W_X36;
    endcase
  end

  for (genvar p = 0; p < DQ_W; p++) begin : g_pin
    assign active[p] = (6'(p) < width) && !release_mask[p];
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_is_gpio <= '1;
      gpio_in     <= '0;
    end else begin
      pin_is_gpio <= ~active;
      gpio_in     <= data_s & ~active;
    end
  end

  // Cell registers: rise capture, latch, fall and output pair
  logic [DQ_W-1:0] rise_cap;
  logic [DQ_W-1:0] rise_latch;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rise_cap <= '0;
    end else if (rise_ev) begin
      rise_cap <= data_s;
    end
  end

  // Holds the rise bit stable while the fall half arrives
  always_comb begin
    rise_latch = rise_cap;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      q_rise     <= '0;
      q_fall     <= '0;
      pair_valid <= 1'b0;
    end else begin
      pair_valid <= fall_ev;
      if (fall_ev) begin
        q_rise <= rise_latch & active;
        q_fall <= data_s & active;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  angle_ceiling_a: assert property (angle <= `SPS_ANGLE_MAX)
    else $error("phase angle above the largest step");
  mode_limit_a: assert property (
    (dll_mode == SPS_DLL_M8 && phase_sel > 3'd2) |-> angle == 11'd0)
    else $error("index beyond mode range gave a shift");
  period_meas_a: assert property (
    (ref_rise && ref_cnt != `SPS_PERIOD_SAT)
      |=> ref_period == $past(ref_cnt) + 8'd1)
    else $error("reference period not measured");
  zero_shift_a: assert property (
    (angle == 11'd0) |=> dll_setting == 8'd0)
    else $error("zero angle left a nonzero setting");
  local_tap_a: assert property (
    (dll_setting < 8'(DEPTH - 4)) |-> tap[1] == TAP_W'(dll_setting
      + {6'd0, fine_adj_comp}))
    else $error("local tap does not add fine offset");
  rise_hold_a: assert property (
    rise_ev |=> rise_cap == $past(data_s))
    else $error("rise capture missed data");
  x4_width_a: assert property (
    (group_mode == SPS_X4) |=> $countones(~pin_is_gpio) <= 4)
    else $error("by-4 group uses more than four pins");
  pair_out_a: assert property (
    fall_ev |=> pair_valid && q_fall == ($past(data_s) & $past(active)))
    else $error("fall bit not presented with pair");
  echo_fall_a: assert property (
    (echo_mode && comp_rise && BANK_CAPABLE) |=> pair_valid)
    else $error("complement edge did not close pair");
  lock_valid_a: assert property (
    dll_locked |-> $past(ref_period) != 8'd0)
    else $error("lock with no period");

  echo_pair_c: cover property (echo_mode && pair_valid);
  dll_lock_c:  cover property ($rose(dll_locked));
  x36_pair_c:  cover property (group_mode == SPS_X36 && pair_valid);

endmodule

`default_nettype wire

/* shared/sps_defines.svh */
// Constants of the strobe phase shift and data capture block
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH

// Phase steps per DLL mode, in tenths of a degree
`define SPS_STEP_M16     11'd225
`define SPS_STEP_M12     11'd300
`define SPS_STEP_M10     11'd360
`define SPS_STEP_M8      11'd450
`define SPS_IDX_MAX      3'd4
`define SPS_IDX_MAX_M8   3'd2
`define SPS_ANGLE_MAX    11'd1440
`define SPS_FULL_TURN    19'd3600

// Group widths, data pins per strobe
`define SPS_W_X4         6'd4
`define SPS_W_X9         6'd9
`define SPS_W_X18        6'd18
`define SPS_W_X36        6'd36

// Highest strobe rate served, in MHz
`define SPS_MAX_RATE_MHZ 300

// Reset values and the period counter ceiling
`define SPS_PERIOD_RST   8'h00
`define SPS_SETTING_RST  8'h00
`define SPS_PERIOD_SAT   8'hFF

`endif

/* shared/sps_pkg.sv */
// Types of the strobe phase shift and data capture block
package sps_pkg;

  typedef enum logic [1:0] {
    SPS_DLL_M16 = 2'b00,
    SPS_DLL_M12 = 2'b01,
    SPS_DLL_M10 = 2'b10,
    SPS_DLL_M8  = 2'b11
  } sps_dll_mode_t;

  typedef enum logic [1:0] {
    SPS_X4  = 2'b00,
    SPS_X9  = 2'b01,
    SPS_X18 = 2'b10,
    SPS_X36 = 2'b11
  } sps_group_t;

endpackage

/* design/sps_delay_line.sv */
// Local delay block: tapped delay line for one strobe input
`timescale 1ns/1ps
`default_nettype none

module sps_delay_line #(
  parameter int DEPTH = 64
) (
  input  wire logic                     clk_sys,
  input  wire logic                     sys_rst,
  input  wire logic                     din,
  input  wire logic [$clog2(DEPTH)-1:0] tap,
  output var  logic                     dout
);

  logic [DEPTH-1:0] line;

  initial begin
    if (DEPTH < 4) begin
      $error("sps_delay_line: DEPTH must be at least 4");
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      line <= '0;
    end else begin
      line <= {line[DEPTH-2:0], din};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dout <= 1'b0;
    end else begin
      dout <= line[tap];
    end
  end

endmodule

`default_nettype wire

/* verif/sps_mem_model.sv */
// Memory device model: strobe or echo clocks with edge-aligned read data
`timescale 1ns/1ps
`default_nettype none

module sps_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        echo,
  output var  logic        strobe,
  output var  logic        complement_strobe,
  output var  logic [35:0] data_pin
);
  // Strobes stand still between bursts
  initial begin
    strobe = 1'b0;
    complement_strobe = 1'b1;
    data_pin = 36'h0_0000_0000;
  end

  // One word per strobe level; complement untouched unless echo clocks
  task automatic burst(input logic [35:0] rw, input logic [35:0] fw,
                       input int half);
    @(posedge clk_sys);
    strobe <= 1'b1;
    if (echo) complement_strobe <= 1'b0;
    data_pin <= rw;
    repeat (half) @(posedge clk_sys);
    strobe <= 1'b0;
    if (echo) complement_strobe <= 1'b1;
    data_pin <= fw;
    repeat (half) @(posedge clk_sys);
    // Released bus shows the inverse so a stale word cannot pass
    data_pin <= ~fw;
  endtask
endmodule

`default_nettype wire

/* verif/strobe_phase_shift_dq_capture_tb.sv */
// Testbench of the strobe phase shift and data capture block
`timescale 1ns/1ps
`default_nettype none
`include "sps_defines.svh"

`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin failures++; \
  $display("MISMATCH t=%0t %s", $time, m); end end

module strobe_phase_shift_dq_capture_tb;
  logic        clk_sys, sys_rst, ref_clk_pin, echo_mode, pair_valid;
  logic        strobe, complement_strobe, dll_locked;
  logic [1:0]  dll_mode, group_mode, fine_adj_strobe, fine_adj_comp;
  logic [2:0]  phase_sel;
  logic [35:0] data_pin, release_mask, q_rise, q_fall, pin_is_gpio;
  logic [35:0] gpio_in, act, rel, rw, fw;
  logic [71:0] exp_q[$];
  logic [71:0] e;
  logic [31:0] lf;
  int          failures, checks, n;

  sps_capture u_sps_capture (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .strobe(strobe), .complement_strobe(complement_strobe),
    .ref_clk_pin(ref_clk_pin), .data_pin(data_pin), .dll_mode(dll_mode),
    .phase_sel(phase_sel), .group_mode(group_mode), .echo_mode(echo_mode),
    .release_mask(release_mask), .fine_adj_strobe(fine_adj_strobe),
    .fine_adj_comp(fine_adj_comp), .q_rise(q_rise), .q_fall(q_fall),
    .pair_valid(pair_valid), .pin_is_gpio(pin_is_gpio),
    .gpio_in(gpio_in), .dll_locked(dll_locked));

  sps_mem_model u_sps_mem_model (.clk_sys(clk_sys), .echo(echo_mode),
    .strobe(strobe), .complement_strobe(complement_strobe),
    .data_pin(data_pin));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0400_0007 : 32'h0000_0000);
  endfunction

  function automatic logic [35:0] wmask(input int g);
    logic [63:0] m;
    m = (64'h1 << (g == 0 ? `SPS_W_X4 : g == 1 ? `SPS_W_X9 :
                   g == 2 ? `SPS_W_X18 : `SPS_W_X36)) - 64'h1;
    return m[35:0];
  endfunction

  task automatic summarize();
    if (failures == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Reference runs free, unrelated in phase to the system clock
  initial begin
    ref_clk_pin = 1'b0;
    #3;
    forever #62.5 ref_clk_pin = ~ref_clk_pin;
  end

  // Each pair must match the oldest noted burst
  always @(posedge clk_sys) begin
    if (sys_rst === 1'b0 && pair_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        `CHK(1'b0, 1'b1, "unexpected pair")
      end else begin
        e = exp_q.pop_front();
        `CHK(q_rise, e[71:36], "rise bits")
        `CHK(q_fall, e[35:0], "fall bits")
      end
    end
  end

  initial begin
    failures = 0;
    checks = 0;
    lf = 32'h7045_9fc3;
    sys_rst = 1'b1;
    dll_mode = 2'b00;
    group_mode = 2'b00;
    phase_sel = 3'h0;
    echo_mode = 1'b0;
    release_mask = 36'h0_0000_0000;
    fine_adj_strobe = 2'b00;
    fine_adj_comp = 2'b00;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // Let the setting settle after two reference rises
    repeat (60) @(posedge clk_sys);
    for (int g = 0; g < 4; g++) begin
      for (int d = 0; d < 4; d++) begin
        lf = lfsr(lf);
        rel = lf[14] ? {4'h0, lf[31:15], 15'h0000} : 36'h0_0000_0000;
        group_mode <= g[1:0];
        dll_mode <= d[1:0];
        phase_sel <= lf[2:0];
        echo_mode <= lf[8];
        fine_adj_strobe <= lf[10:9];
        fine_adj_comp <= lf[12:11];
        release_mask <= rel;
        repeat (4) @(posedge clk_sys);
        act = wmask(g) & ~rel;
        `CHK(pin_is_gpio, ~act, "released pins")
        for (int b = 0; b < 2; b++) begin
          lf = lfsr(lf);
          rw = {lf[3:0], lf};
          lf = lfsr(lf);
          fw = {lf[7:4], lf};
          exp_q.push_back({rw & act, fw & act});
          u_sps_mem_model.burst(rw, fw, 20);
          n = 0;
          while (exp_q.size() != 0 && n < 300) begin
            @(posedge clk_sys);
            n++;
          end
          if (n == 300) begin
            failures++;
            summarize();
          end
        end
        // Flush the strobe tails out of the delay lines before a new tap
        repeat (70) @(posedge clk_sys);
        `CHK(gpio_in, ~fw & ~act, "plain pin value")
      end
    end
    summarize();
  end
endmodule

`default_nettype wire
